//--- verilog/dpr_top.sv
// Indirect PORT RAM access block: Avalon-MM slave, access engine and DS0 datapath.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_regs.svh"
// Summary of operation
// - select 00 data, 01 receive, 10 transmit
// - direction 1 starts fetch, sets busy
// - read busy clears once data ready
// - direction 0 stores data register
// - busy read-only, clears after write
// - data register carries full 16-bit word
// - low byte keeps latest received byte
// - high byte keeps latest transmitted byte
// - channel code means channel code plus one
// - unchannelized uses entry 0 channel number
// - 56k drops LSB toward HDLC, BERT when channelized
// - V.54 search always sees 8 bits
// - local loopback needs enable and 64k
// - V.54 bit selects DS0 for search
// - BERT bit routes receive data out
// - enable gates HDLC, not BERT/V.54
// - local loopback returns transmit data
// - unchannelized honours entry 0 enable
// - transmit entry field layout
// - select bits 6:0 hold DS0 index
module dpr_top
    import dpr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Received DS0 bytes
    input wire logic rx_ds0_valid,
    input wire logic [6:0] rx_ds0_index,
    input wire logic [7:0] rx_ds0_byte,
    // Transmitted DS0 bytes
    input wire logic tx_ds0_valid,
    input wire logic [6:0] tx_ds0_index,
    input wire logic [7:0] tx_ds0_byte,
    // Receive results
    output dpr_rx_out_s rx_out,
    // Transmit side view
    output logic [7:0] tx_loop_byte,
    output dpr_txcfg_s tx_cfg
);
    logic wait_r;
    logic [31:0] rdata_r;
    logic [6:0] idx_r;
    logic [1:0] tsel_r;
    logic dir_r;
    logic busy_r;
    logic [15:0] word_r;
    logic rx_unch_r;
    logic tx_unch_r;
    dpr_state_e state_r;
    dpr_rx_out_s rx_out_r;
    dpr_rx_out_s rx_nxt;
    logic [7:0] tx_loop_r;
    dpr_txcfg_s tx_cfg_r;
    logic acc_wr;
    logic sel_hit;
    logic start;
    logic store_go;
    logic [15:0] sel_word;
    logic [15:0] host_word;
    logic [2:0][6:0] dat_ra;
    logic [2:0][15:0] dat_rd;
    logic [1:0][6:0] rxc_ra;
    logic [1:0][15:0] rxc_rd;
    logic [1:0][6:0] txc_ra;
    logic [1:0][15:0] txc_rd;
    logic [1:0] dat_we;
    logic [1:0][6:0] dat_wa;
    logic [1:0][7:0] dat_wd;
    logic [1:0] rxc_we;
    logic [1:0] txc_we;
    logic [1:0][6:0] cfg_wa;
    logic [1:0][7:0] cfg_wd;

    // The slave answers one cycle after a request is seen, so each access takes two cycles.
    assign acc_wr = avs_write && !wait_r;
    assign sel_hit = acc_wr && (avs_address == `DPR_OFS_SELECT) && !busy_r;
    assign start = sel_hit && avs_byteenable[1];
    assign store_go = (state_r == ST_STORE);
    assign sel_word = {busy_r, dir_r, 4'h0, tsel_r, 1'b0, idx_r};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 1'b1;
        end else if ((avs_read || avs_write) && wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 32'h00000000;
        end else if (avs_read && wait_r) begin
            if (avs_address == `DPR_OFS_SELECT) begin
                rdata_r <= {16'h0000, sel_word};
            end else if (avs_address == `DPR_OFS_DATA) begin
                rdata_r <= {16'h0000, word_r};
            end else if (avs_address == `DPR_OFS_MODE) begin
                rdata_r <= {30'h0, tx_unch_r, rx_unch_r};
            end else begin
                rdata_r <= 32'h00000000;
            end
        end
    end

    // The select fields are frozen while an access runs, so the engine sees stable targets.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            idx_r <= 7'h00;
            tsel_r <= 2'h0;
            dir_r <= 1'b0;
        end else if (sel_hit) begin
            if (avs_byteenable[0]) begin
                idx_r <= avs_writedata[`DPR_SEL_IDX_LSB +: `DPR_IDX_W];
            end
            if (avs_byteenable[1]) begin
                tsel_r <= avs_writedata[`DPR_SEL_TBL_LSB +: 2];
                dir_r <= avs_writedata[`DPR_SEL_DIR_BIT];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_unch_r <= 1'b0;
            tx_unch_r <= 1'b0;
        end else if (acc_wr && (avs_address == `DPR_OFS_MODE) && avs_byteenable[0]) begin
            rx_unch_r <= avs_writedata[`DPR_MODE_RX_UNCH_BIT];
            tx_unch_r <= avs_writedata[`DPR_MODE_TX_UNCH_BIT];
        end
    end

    always_comb begin
        if (tsel_r == `DPR_TBL_DATA) begin
            host_word = dat_rd[0];
        end else if (tsel_r == `DPR_TBL_RXCFG) begin
            host_word = rxc_rd[0];
        end else if (tsel_r == `DPR_TBL_TXCFG) begin
            host_word = txc_rd[0];
        end else begin
            host_word = 16'h0000;
        end
    end

    // A fetch overwrites the data register even if the host wrote it in the same cycle.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            word_r <= `DPR_DATA_RESET;
        end else if (state_r == ST_FETCH) begin
            // full word lands in data register
            word_r <= host_word;
        end else if (acc_wr && (avs_address == `DPR_OFS_DATA)) begin
            if (avs_byteenable[0]) begin
                word_r[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                word_r[15:8] <= avs_writedata[15:8];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        busy_r <= 1'b1;
                        state_r <= avs_writedata[`DPR_SEL_DIR_BIT] ? ST_FETCH : ST_STORE;
                    end
                end
                ST_FETCH: begin
                    busy_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                ST_STORE: begin
                    busy_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: begin
                    busy_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign rxc_we = {2{store_go && (tsel_r == `DPR_TBL_RXCFG)}};
    assign txc_we = {2{store_go && (tsel_r == `DPR_TBL_TXCFG)}};
    assign cfg_wa = {idx_r, idx_r};
    assign cfg_wd = {word_r[15:8], word_r[7:0]};

    // received byte kept in low lane
    // transmitted byte kept in high lane
    // Stream updates win a lane over a host store, which software must not issue anyway.
    always_comb begin
        dat_we[0] = rx_ds0_valid || (store_go && (tsel_r == `DPR_TBL_DATA));
        dat_wa[0] = rx_ds0_valid ? rx_ds0_index : idx_r;
        dat_wd[0] = rx_ds0_valid ? rx_ds0_byte : word_r[7:0];
        dat_we[1] = tx_ds0_valid || (store_go && (tsel_r == `DPR_TBL_DATA));
        dat_wa[1] = tx_ds0_valid ? tx_ds0_index : idx_r;
        dat_wd[1] = tx_ds0_valid ? tx_ds0_byte : word_r[15:8];
    end

    assign dat_ra = {tx_ds0_index, rx_ds0_index, idx_r};
    // entry 0 enable for whole port
    assign rxc_ra = {(rx_unch_r ? 7'h00 : rx_ds0_index), idx_r};
    assign txc_ra = {(tx_unch_r ? 7'h00 : tx_ds0_index), idx_r};

    dpr_ram #(.NRD(3)) u_dat (
        .mclk(mclk),
        .we(dat_we),
        .wr_addr(dat_wa),
        .din(dat_wd),
        .rd_addr(dat_ra),
        .rd_data(dat_rd)
    );

    dpr_ram #(.NRD(2)) u_rxc (
        .mclk(mclk),
        .we(rxc_we),
        .wr_addr(cfg_wa),
        .din(cfg_wd),
        .rd_addr(rxc_ra),
        .rd_data(rxc_rd)
    );

    dpr_ram #(.NRD(2)) u_txc (
        .mclk(mclk),
        .we(txc_we),
        .wr_addr(cfg_wa),
        .din(cfg_wd),
        .rd_addr(txc_ra),
        .rd_data(txc_rd)
    );

    dpr_rx_path u_rx (
        .valid(rx_ds0_valid),
        .rx_byte(rx_ds0_byte),
        .tx_hist(dat_rd[1][15:8]),
        .cfg(dpr_rxcfg_s'(rxc_rd[1])),
        .unch(rx_unch_r),
        .res(rx_nxt)
    );

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_out_r <= '0;
        end else begin
            rx_out_r <= rx_nxt;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_loop_r <= 8'h00;
            tx_cfg_r <= '0;
        end else begin
            tx_loop_r <= dat_rd[2][7:0];
            tx_cfg_r <= dpr_txcfg_s'(txc_rd[1]);
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign rx_out = rx_out_r;
    assign tx_loop_byte = tx_loop_r;
    assign tx_cfg = tx_cfg_r;

    a_wait_answers: assert property (@(posedge mclk) disable iff (!nrst)
        (avs_read || avs_write) && wait_r |=> !wait_r ##1 wait_r)
        else $error("waitrequest did not drop for exactly one cycle");

    a_busy_on_start: assert property (@(posedge mclk) disable iff (!nrst)
        start |=> busy_r && (state_r != ST_IDLE))
        else $error("start did not raise busy");

    a_busy_clears: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(busy_r) |=> !busy_r && (state_r == ST_IDLE))
        else $error("busy did not clear one cycle after start");

    a_fetch_loads: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == ST_FETCH) |=> (word_r == $past(host_word)) && !busy_r)
        else $error("fetched word missing when busy cleared");

    a_store_rxcfg: assert property (@(posedge mclk) disable iff (!nrst)
        store_go && (tsel_r == `DPR_TBL_RXCFG) |=> (rxc_rd[0] == $past(word_r)))
        else $error("receive entry not stored");

    a_illegal_zero: assert property (@(posedge mclk) disable iff (!nrst)
        (state_r == ST_FETCH) && (tsel_r == `DPR_TBL_ILLEGAL) |=> (word_r == 16'h0000))
        else $error("illegal table read returned data");

    a_rx_hist_kept: assert property (@(posedge mclk) disable iff (!nrst)
        rx_ds0_valid
        |=> (dat_rd[2][7:0] == $past(rx_ds0_byte)) || (tx_ds0_index != $past(rx_ds0_index)))
        else $error("received byte not kept");

    a_loop_data: assert property (@(posedge mclk) disable iff (!nrst)
        rx_ds0_valid && !rx_unch_r && rxc_rd[1][10] && rxc_rd[1][15] && !rxc_rd[1][8]
        |=> rx_out.hdlc_valid && (rx_out.hdlc_data == $past(dat_rd[1][15:8])))
        else $error("local loopback data wrong");

    a_seven_lsb: assert property (@(posedge mclk) disable iff (!nrst)
        rx_ds0_valid && !rx_unch_r && rxc_rd[1][8]
        |=> rx_out.hdlc_seven && !rx_out.hdlc_data[0] && !rx_out.bert_data[0])
        else $error("56k LSB not dropped");

    a_v54_raw: assert property (@(posedge mclk) disable iff (!nrst)
        rx_ds0_valid |=> (rx_out.v54_data == $past(rx_ds0_byte)))
        else $error("V.54 data not the raw byte");

    a_chan_plus: assert property (@(posedge mclk) disable iff (!nrst)
        rx_ds0_valid |=> (rx_out.hdlc_chan == ({1'b0, $past(rxc_rd[1][7:0])} + 9'h001)))
        else $error("channel number mapping wrong");

    a_bert_route: assert property (@(posedge mclk) disable iff (!nrst)
        rx_ds0_valid |=> (rx_out.bert_valid == $past(rxc_rd[1][14])))
        else $error("BERT routing does not follow its bit");
endmodule
`default_nettype wire

//--- verilog/dpr_regs.svh
// Register offsets, field positions and reset values of the indirect PORT RAM block.
`ifndef DPR_REGS_SVH
`define DPR_REGS_SVH
`define DPR_OFS_SELECT 4'h0
`define DPR_OFS_DATA 4'h4
`define DPR_OFS_MODE 4'h8
`define DPR_DEPTH 128
`define DPR_IDX_W 7
`define DPR_SEL_IDX_LSB 0
`define DPR_SEL_TBL_LSB 8
`define DPR_SEL_DIR_BIT 14
`define DPR_SEL_BUSY_BIT 15
`define DPR_TBL_DATA 2'h0
`define DPR_TBL_RXCFG 2'h1
`define DPR_TBL_TXCFG 2'h2
`define DPR_TBL_ILLEGAL 2'h3
`define DPR_MODE_RX_UNCH_BIT 0
`define DPR_MODE_TX_UNCH_BIT 1
`define DPR_DATA_RESET 16'h0000
`define DPR_CHAN_OFFSET 9'h001
`endif

//--- verilog/dpr_pkg.sv
// Types shared by the indirect PORT RAM block.
`default_nettype none
`include "dpr_regs.svh"
package dpr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_STORE = 3'b100
    } dpr_state_e;
    typedef struct packed {
        logic active;
        logic to_bert;
        logic rsv13;
        logic v54;
        logic rsv11;
        logic lloop;
        logic rsv9;
        logic seven;
        logic [7:0] chan;
    } dpr_rxcfg_s;
    typedef struct packed {
        logic active;
        logic from_bert;
        logic rsv13;
        logic rsv12;
        logic net_loop;
        logic rsv10;
        logic force_ones;
        logic seven;
        logic [7:0] chan;
    } dpr_txcfg_s;
    typedef struct packed {
        logic hdlc_valid;
        logic [8:0] hdlc_chan;
        logic [7:0] hdlc_data;
        logic hdlc_seven;
        logic bert_valid;
        logic [7:0] bert_data;
        logic v54_valid;
        logic [7:0] v54_data;
    } dpr_rx_out_s;
endpackage
`default_nettype wire

//--- verilog/dpr_ram.sv
// One 128-entry PORT RAM table with a write port per byte lane.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_regs.svh"
module dpr_ram
    import dpr_pkg::*;
#(
    parameter int NRD = 2
) (
    // Clock
    input wire logic mclk,
    // Lane writes, lane 0 is bits 7:0
    input wire logic [1:0] we,
    input wire logic [1:0][6:0] wr_addr,
    input wire logic [1:0][7:0] din,
    // Read ports
    input wire logic [NRD-1:0][6:0] rd_addr,
    output logic [NRD-1:0][15:0] rd_data
);
    // Contents have no reset; software initialises every entry it uses.
    for (genvar l = 0; l < 2; l++) begin : g_lane
        logic [7:0] mem [0:`DPR_DEPTH-1];
        always_ff @(posedge mclk) begin
            if (we[l]) begin
                mem[wr_addr[l]] <= din[l];
            end
        end
        for (genvar r = 0; r < NRD; r++) begin : g_rd
            assign rd_data[r][8*l +: 8] = mem[rd_addr[r]];
        end
    end
endmodule
`default_nettype wire

//--- verilog/dpr_rx_path.sv
// Receive DS0 steering: loopback, 56k masking, BERT and V.54 routing.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_regs.svh"
module dpr_rx_path
    import dpr_pkg::*;
(
    // Incoming DS0 byte
    input wire logic valid,
    input wire logic [7:0] rx_byte,
    input wire logic [7:0] tx_hist,
    // Configuration of this DS0 and port mode
    input wire dpr_rxcfg_s cfg,
    input wire logic unch,
    // Steered result
    output dpr_rx_out_s res
);
    logic chz;
    logic loop;
    logic seven;
    logic [7:0] data;
    logic [7:0] masked;
    assign chz = !unch;
    assign loop = chz && cfg.lloop && cfg.active && !cfg.seven;
    assign data = loop ? tx_hist : rx_byte;
    assign seven = chz && cfg.seven;
    assign masked = seven ? {data[7:1], 1'b0} : data;
    always_comb begin
        res.hdlc_valid = valid && cfg.active;
        res.hdlc_chan = {1'b0, cfg.chan} + `DPR_CHAN_OFFSET;
        res.hdlc_data = masked;
        res.hdlc_seven = seven;
        res.bert_valid = valid && cfg.to_bert;
        res.bert_data = masked;
        res.v54_valid = valid && (unch || cfg.v54);
        res.v54_data = rx_byte;
    end
endmodule
`default_nettype wire

//--- bench/dpr_top_test.sv
// Self-checking testbench of the indirect PORT RAM access block.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_regs.svh"
module dpr_top_test
    import dpr_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rx_ds0_valid = 1'b0;
    logic [6:0] rx_ds0_index = 7'h00;
    logic [7:0] rx_ds0_byte = 8'h00;
    logic tx_ds0_valid = 1'b0;
    logic [6:0] tx_ds0_index = 7'h00;
    logic [7:0] tx_ds0_byte = 8'h00;
    dpr_rx_out_s rx_out;
    logic [7:0] tx_loop_byte;
    dpr_txcfg_s tx_cfg;
    int failures = 0;
    int num_checks = 0;

    always #50 mclk = ~mclk;

    dpr_top dut (
        .mclk(mclk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_ds0_valid(rx_ds0_valid), .rx_ds0_index(rx_ds0_index), .rx_ds0_byte(rx_ds0_byte),
        .tx_ds0_valid(tx_ds0_valid), .tx_ds0_index(tx_ds0_index), .tx_ds0_byte(tx_ds0_byte),
        .rx_out(rx_out), .tx_loop_byte(tx_loop_byte), .tx_cfg(tx_cfg)
    );

    task automatic end_of_test();
        $display("Checks made %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Waitrequest is read at each rising edge, before the design updates it there.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        q = 32'h0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            failures++;
            $display("Error waitrequest expected 0 seen %b", avs_waitrequest);
            end_of_test();
        end else begin
            q = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 16'h0000, 4'hF, q);
    endtask

    function automatic logic [15:0] selw(input logic dir, input logic [1:0] t,
                                         input logic [6:0] idx);
        logic [15:0] w;
        w = 16'h0000;
        w[6:0] = idx;
        w[9:8] = t;
        w[14] = dir;
        return w;
    endfunction

    task automatic ind_wr(input logic [1:0] t, input logic [6:0] idx, input logic [15:0] v);
        wr(`DPR_OFS_DATA, v, 4'hF);
        wr(`DPR_OFS_SELECT, selw(1'b0, t, idx), 4'hF);
    endtask

    task automatic ind_rd(input logic [1:0] t, input logic [6:0] idx, output logic [31:0] q);
        wr(`DPR_OFS_SELECT, selw(1'b1, t, idx), 4'hF);
        rd(`DPR_OFS_SELECT, q);
        check("select and busy", {16'h0000, selw(1'b1, t, idx)}, q);
        rd(`DPR_OFS_DATA, q);
    endtask

    task automatic tx_send(input logic [6:0] idx, input logic [7:0] b);
        tx_ds0_index <= idx;
        tx_ds0_byte <= b;
        tx_ds0_valid <= 1'b1;
        @(posedge mclk);
        tx_ds0_valid <= 1'b0;
        @(posedge mclk);
    endtask

    // The first cycle that shows any pulse is taken as the answer to this byte.
    task automatic rx_send(input logic [6:0] idx, input logic [7:0] b, output dpr_rx_out_s got);
        logic seen;
        got = '0;
        seen = 1'b0;
        rx_ds0_index <= idx;
        rx_ds0_byte <= b;
        rx_ds0_valid <= 1'b1;
        @(posedge mclk);
        rx_ds0_valid <= 1'b0;
        repeat (3) begin
            @(negedge mclk);
            if (!seen && (rx_out.hdlc_valid | rx_out.bert_valid | rx_out.v54_valid) === 1'b1) begin
                got = rx_out;
                seen = 1'b1;
            end
            @(posedge mclk);
        end
    endtask

    function automatic dpr_rx_out_s exp_rx(input dpr_rxcfg_s c, input logic [7:0] b,
                                           input logic [7:0] t, input logic u);
        dpr_rx_out_s e;
        logic [7:0] d;
        e = '0;
        d = (!u && c.lloop && c.active && !c.seven) ? t : b;
        if (!u && c.seven) begin
            d[0] = 1'b0;
        end
        e.hdlc_valid = c.active;
        e.hdlc_chan = {1'b0, c.chan} + 9'h001;
        e.hdlc_data = d;
        e.hdlc_seven = !u && c.seven;
        e.bert_valid = c.to_bert;
        e.bert_data = d;
        e.v54_valid = u || c.v54;
        e.v54_data = b;
        return e;
    endfunction

    initial begin
        logic [31:0] q;
        logic [15:0] v;
        logic [6:0] idx, cidx;
        logic [7:0] tb, rb;
        logic [1:0] tbl;
        logic u;
        int k;
        dpr_rx_out_s got, e;
        q = $urandom(88074);
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(`DPR_OFS_SELECT, q);
        check("select reset", 32'h0, q);
        rd(`DPR_OFS_DATA, q);
        check("data reset", 32'h0, q);
        rd(`DPR_OFS_MODE, q);
        check("mode reset", 32'h0, q);
        wr(4'hC, 16'hFFFF, 4'hF);
        rd(4'hC, q);
        check("unmapped read", 32'h0, q);
        $display("Test reset_values done");
        wr(`DPR_OFS_DATA, 16'hA55A, 4'hF);
        wr(`DPR_OFS_DATA, 16'h00C3, 4'h1);
        rd(`DPR_OFS_DATA, q);
        check("data lane 0", 32'h0000A5C3, q);
        wr(`DPR_OFS_DATA, 16'h3C00, 4'h2);
        rd(`DPR_OFS_DATA, q);
        check("data lane 1", 32'h00003CC3, q);
        $display("Test byte_lanes done");
        for (int i = 0; i < 24; i++) begin
            u = (i >= 16);
            if (i == 16) begin
                wr(`DPR_OFS_MODE, 16'h0003, 4'hF);
                rd(`DPR_OFS_MODE, q);
                check("mode word", 32'h3, q);
            end
            tbl = i[0] ? `DPR_TBL_TXCFG : `DPR_TBL_RXCFG;
            k = i >> 1;
            idx = (i < 4) ? (i[1] ? 7'h7F : 7'h00) : 7'($urandom);
            cidx = u ? 7'h00 : idx;
            v = 16'($urandom);
            if (tbl == `DPR_TBL_RXCFG) begin
                v[15] = k[0];
                v[10] = k[1];
                v[8] = k[2];
            end
            ind_wr(tbl, cidx, v);
            ind_rd(tbl, cidx, q);
            check("table word", {16'h0000, v}, q);
            if (tbl == `DPR_TBL_TXCFG) begin
                tx_ds0_index <= idx;
                repeat (3) @(posedge mclk);
                @(negedge mclk);
                check("tx_cfg", {16'h0000, v}, {16'h0000, tx_cfg});
                @(posedge mclk);
            end else begin
                tb = 8'($urandom);
                rb = 8'($urandom);
                tx_send(idx, tb);
                rx_send(idx, rb, got);
                e = exp_rx(dpr_rxcfg_s'(v), rb, tb, u);
                check("rx pulses", {29'h0, e.hdlc_valid, e.bert_valid, e.v54_valid},
                      {29'h0, got.hdlc_valid, got.bert_valid, got.v54_valid});
                if (e.hdlc_valid) begin
                    check("hdlc fields", {14'h0, e.hdlc_chan, e.hdlc_data, e.hdlc_seven},
                          {14'h0, got.hdlc_chan, got.hdlc_data, got.hdlc_seven});
                end
                if (e.bert_valid && !(v[10] && v[15] && !v[8] && !u)) begin
                    check("bert data", {24'h0, e.bert_data}, {24'h0, got.bert_data});
                end
                if (e.v54_valid) begin
                    check("v54 data", {24'h0, e.v54_data}, {24'h0, got.v54_data});
                end
                if (!u) begin
                    ind_rd(`DPR_TBL_DATA, idx, q);
                    check("ds0 bytes", {16'h0000, tb, rb}, q);
                    @(negedge mclk);
                    check("tx_loop_byte", {24'h0, rb}, {24'h0, tx_loop_byte});
                    @(posedge mclk);
                end
            end
        end
        $display("Test table_access done");
        ind_wr(`DPR_TBL_ILLEGAL, 7'h05, 16'h1234);
        wr(`DPR_OFS_SELECT, selw(1'b1, `DPR_TBL_ILLEGAL, 7'h05), 4'hF);
        rd(`DPR_OFS_DATA, q);
        check("illegal table read", 32'h0, q);
        $display("Test illegal_select done");
        end_of_test();
    end
endmodule
`default_nettype wire
